// file: verilog/psup_top.sv
// psup_top: protection status encoding and reaction sequencing
// assumes analog comparator levels arrive asynchronously on pins and
// that firmware sidebands (kicks, crc result) come from mclk logic
`timescale 1ns/10ps

// Functional notes
// - bits 6,5,4 flag nonzero light, flyback, power-factor fault words
// - bits 3..0 hold index of a set bit in a fault word
// - with several bits set, report only the first found
// - low seven bits: 45 parity, 46 watchdog, 47 clock check
// - overtemperature from sensor above trip or thermistor below trip
// - auto restart waits for temperature and thermistor release
// - latched overtemperature restarts only after power cycle with sensor not above trip
// - supply lockout with enable and lower disable hysteresis
// - supply overvoltage after blanking time
// - supply overvoltage reaction always stop
// - supply undervoltage after blanking time
// - watchdog fault when firmware misses service period
// - memory parity mismatch raises a fault
// - clock check fault on any failed oscillator
// - crc over firmware and parameters checked at every startup
// - task monitor fault when tasks do not run
// - temperature, undervoltage, stage and system faults each have a selectable reaction
// - supply and temperature faults trigger only after condition outlasts blanking time
// - owner gate off within 160 us, others within further 160 us
// - latch reaction ends latched off
// - stop reaction halts into uart parametrization state
// - auto restarts wait configured restart time in power saving
// - bit 7 high while a reaction is in progress
module psup_top #(
    parameter int FLAG_W       = 16,
    parameter int N_OSC        = 2,
    parameter int RST_CYC      = 20000000,
    parameter int FAST_CYC     = 2000000,
    parameter int BLANK_CYCLES = psup_pkg::BLANK_CYC,
    parameter int WDOG_CYCLES  = psup_pkg::WDOG_CYC,
    parameter int TASK_CYCLES  = psup_pkg::TASK_CYC,
    parameter int STEP_CYCLES  = psup_pkg::STEP_CYC
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // stage fault words
    input  wire logic [FLAG_W-1:0] power_factor_fault_flags,
    input  wire logic [FLAG_W-1:0] flyback_fault_flags,
    input  wire logic [FLAG_W-1:0] light_management_fault_flags,
    input  wire logic [1:0]        stage_react,
    // analog comparator pins
    input  wire logic              temp_over_trip,
    input  wire logic              temp_below_release,
    input  wire logic              therm_below_trip,
    input  wire logic              therm_above_release,
    input  wire logic              supply_above_enable_level,
    input  wire logic              supply_above_disable_level,
    input  wire logic              supply_above_high_limit,
    input  wire logic              supply_below_low_limit,
    input  wire logic              power_cycled,
    // firmware integrity sidebands
    input  wire logic              wdog_kick,
    input  wire logic              task_tick,
    input  wire logic              parity_error,
    input  wire logic [N_OSC-1:0]  osc_alive,
    input  wire logic              crc_done,
    input  wire logic              crc_ok,
    // reaction configuration
    input  wire logic [1:0]        temp_react,
    input  wire logic [1:0]        uv_react,
    input  wire logic [1:0]        sys_react,
    // outputs
    output logic [15:0]            protection_status_word,
    output logic                   gate_drive_pf_en,
    output logic                   gate_drive_fb_en,
    output logic                   power_save,
    output logic                   uart_param_mode,
    output logic                   crc_fail
);
    initial begin
        if (FLAG_W < 1 || FLAG_W > 16 || N_OSC < 1 || STEP_CYCLES < 1)
            $error("psup_top: unsupported parameter values");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NP = 9;
    logic [NP-1:0] pin_raw, sync1_ff, sync2_ff;
    assign pin_raw = {temp_over_trip, temp_below_release, therm_below_trip,
                      therm_above_release, supply_above_enable_level,
                      supply_above_disable_level, supply_above_high_limit,
                      supply_below_low_limit, power_cycled};
    // two flops on each async pin
    always_ff @(posedge mclk) begin
        sync1_ff <= pin_raw;
        sync2_ff <= sync1_ff;
    end
    wire t_hot   = sync2_ff[8];
    wire t_cool  = sync2_ff[7];
    wire n_hot   = sync2_ff[6];
    wire n_cool  = sync2_ff[5];
    wire v_en    = sync2_ff[4];
    wire v_dis   = sync2_ff[3];
    wire v_ov    = sync2_ff[2];
    wire v_uv    = sync2_ff[1];
    wire pwr_cyc = sync2_ff[0];

    // ------------------------------------------------------------
    // supply lockout and blanking
    // ------------------------------------------------------------
    logic supply_ok_ff;
    // hysteresis between enable and disable levels
    always_ff @(posedge mclk) begin
        if (rst) supply_ok_ff <= 1'b0;
        else if (v_en) supply_ok_ff <= 1'b1;
        else if (!v_dis) supply_ok_ff <= 1'b0;
    end

    // blanking counters: 0 overvoltage, 1 undervoltage, 2 temperature
    wire [2:0] cond = {t_hot | n_hot, v_uv, v_ov};
    logic [2:0] trig;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_blank
            logic [31:0] bcnt_ff;
            // count while condition holds, trip past blanking time
            always_ff @(posedge mclk) begin
                if (rst || !cond[g]) bcnt_ff <= 32'h0;
                else if (bcnt_ff <= 32'(BLANK_CYCLES))
                    bcnt_ff <= bcnt_ff + 32'h1;
            end
            assign trig[g] = bcnt_ff > 32'(BLANK_CYCLES);
        end
    endgenerate

    // ------------------------------------------------------------
    // firmware integrity monitors
    // ------------------------------------------------------------
    logic [31:0] wdog_ff, task_ff;
    logic        parity_ff, clk_fail_ff, crc_fail_ff;
    // service timers for watchdog and task monitor
    always_ff @(posedge mclk) begin
        if (rst || wdog_kick) wdog_ff <= 32'h0;
        else if (wdog_ff <= 32'(WDOG_CYCLES)) wdog_ff <= wdog_ff + 32'h1;
        if (rst || task_tick) task_ff <= 32'h0;
        else if (task_ff <= 32'(TASK_CYCLES)) task_ff <= task_ff + 32'h1;
    end
    wire wdog_err = wdog_ff > 32'(WDOG_CYCLES);
    wire task_err = task_ff > 32'(TASK_CYCLES);
    // sticky parity, clock and crc faults
    always_ff @(posedge mclk) begin
        if (rst) begin
            parity_ff   <= 1'b0;
            clk_fail_ff <= 1'b0;
            crc_fail_ff <= 1'b0;
        end else begin
            if (parity_error) parity_ff <= 1'b1;
            if (!(&osc_alive)) clk_fail_ff <= 1'b1;
            if (crc_done && !crc_ok) crc_fail_ff <= 1'b1;
        end
    end
    assign crc_fail = crc_fail_ff;

    // ------------------------------------------------------------
    // status encoding
    // ------------------------------------------------------------
    wire pf_any = |power_factor_fault_flags;
    wire fb_any = |flyback_fault_flags;
    wire lm_any = |light_management_fault_flags;
    wire [FLAG_W-1:0] srch = pf_any ? power_factor_fault_flags :
                             fb_any ? flyback_fault_flags :
                             light_management_fault_flags;
    logic [3:0] first_idx;
    // lowest set bit of the first nonzero word wins
    always_comb begin
        first_idx = 4'h0;
        for (int i = FLAG_W - 1; i >= 0; i--)
            if (srch[i]) first_idx = 4'(i);
    end
    wire sys_any = parity_ff | wdog_err | clk_fail_ff;
    wire [6:0] sys_code = parity_ff   ? psup_pkg::CODE_PARITY :
                          wdog_err    ? psup_pkg::CODE_WDOG :
                          clk_fail_ff ? psup_pkg::CODE_CLKCHK :
                          psup_pkg::CODE_NONE;
    wire [6:0] low7 = sys_any ? sys_code :
                      {lm_any, fb_any, pf_any, first_idx};

    // ------------------------------------------------------------
    // reaction sequencer
    // ------------------------------------------------------------
    psup_pkg::psup_state_e st_ff, nxt_st;
    logic [31:0] tmr_ff, nxt_tmr;
    logic [1:0]  rx_ff, own_ff, nxt_rx, nxt_own;
    logic        tmp_ff, nxt_tmp;
    wire stage_err = pf_any | fb_any | lm_any;
    wire any_trig  = trig[0] | trig[1] | trig[2] | stage_err | sys_any |
                     task_err | crc_fail_ff;
    // pick reaction of the highest-priority active fault
    assign nxt_rx  = trig[0] ? psup_pkg::RX_STOP :
                     trig[2] ? temp_react :
                     trig[1] ? uv_react :
                     stage_err ? stage_react : sys_react;
    // supply, temperature and system faults stop both stages at once
    wire gen_err = trig[0] | trig[1] | trig[2] | sys_any;
    assign nxt_own = gen_err ? psup_pkg::OWN_ALL :
                     pf_any  ? psup_pkg::OWN_PF :
                     fb_any  ? psup_pkg::OWN_FB : psup_pkg::OWN_ALL;
    wire step_done = tmr_ff >= 32'(STEP_CYCLES - 1);
    wire wait_done = tmr_ff >= ((rx_ff == psup_pkg::RX_FAST) ?
                     32'(FAST_CYC - 1) : 32'(RST_CYC - 1));
    wire temp_clear = t_cool && n_cool;

    // next-state decode
    always_comb begin
        nxt_st  = st_ff;
        nxt_tmr = tmr_ff + 32'h1;
        nxt_tmp = tmp_ff;
        unique case (st_ff)
            psup_pkg::ST_OFF: begin
                nxt_tmr = 32'h0;
                if (supply_ok_ff && !crc_fail_ff) nxt_st = psup_pkg::ST_RUN;
            end
            psup_pkg::ST_RUN: begin
                nxt_tmr = 32'h0;
                nxt_tmp = trig[2];
                if (!supply_ok_ff) nxt_st = psup_pkg::ST_OFF;
                else if (any_trig) nxt_st = psup_pkg::ST_OWNER;
            end
            psup_pkg::ST_OWNER: if (step_done) begin
                nxt_st  = psup_pkg::ST_OTHERS;
                nxt_tmr = 32'h0;
            end
            psup_pkg::ST_OTHERS: if (step_done) begin
                nxt_tmr = 32'h0;
                unique case (rx_ff)
                    psup_pkg::RX_LATCH: nxt_st = psup_pkg::ST_LATCHED;
                    psup_pkg::RX_STOP:  nxt_st = psup_pkg::ST_STOPPED;
                    default:            nxt_st = psup_pkg::ST_WAIT;
                endcase
            end
            psup_pkg::ST_WAIT: begin
                if (wait_done && (!tmp_ff || temp_clear))
                    nxt_st = psup_pkg::ST_OFF;
                else if (wait_done) nxt_tmr = tmr_ff;
            end
            psup_pkg::ST_LATCHED: begin
                nxt_tmr = 32'h0;
                if (pwr_cyc && !t_hot) nxt_st = psup_pkg::ST_OFF;
            end
            psup_pkg::ST_STOPPED: nxt_tmr = 32'h0;
        endcase
    end

    // state, timer and captured reaction
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff  <= psup_pkg::ST_OFF;
            tmr_ff <= 32'h0;
            rx_ff  <= psup_pkg::RX_AUTO;
            own_ff <= psup_pkg::OWN_ALL;
            tmp_ff <= 1'b0;
        end else begin
            st_ff  <= nxt_st;
            tmr_ff <= nxt_tmr;
            tmp_ff <= nxt_tmp;
            if (st_ff == psup_pkg::ST_RUN) begin
                rx_ff  <= nxt_rx;
                own_ff <= nxt_own;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    wire in_run  = nxt_st == psup_pkg::ST_RUN;
    wire in_own  = nxt_st == psup_pkg::ST_OWNER;
    wire busy    = !(nxt_st == psup_pkg::ST_RUN ||
                     nxt_st == psup_pkg::ST_OFF);
    // fresh owner on the entry edge, so the healthy gate never blinks off
    wire [1:0] own_sel = (st_ff == psup_pkg::ST_RUN) ? nxt_own : own_ff;
    wire nxt_pf  = in_run || (in_own && own_sel == psup_pkg::OWN_FB);
    wire nxt_fb  = in_run || (in_own && own_sel == psup_pkg::OWN_PF);
    always_ff @(posedge mclk) begin
        if (rst) begin
            protection_status_word <= psup_pkg::STAT_RESET;
            gate_drive_pf_en       <= 1'b0;
            gate_drive_fb_en       <= 1'b0;
            power_save             <= 1'b0;
            uart_param_mode        <= 1'b0;
        end else begin
            protection_status_word <= {8'h00, busy, low7};
            gate_drive_pf_en <= nxt_pf;
            gate_drive_fb_en <= nxt_fb;
            power_save <= nxt_st == psup_pkg::ST_WAIT;
            uart_param_mode <= nxt_st == psup_pkg::ST_STOPPED;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    stat_flags_a: assert property (##1 protection_status_word[5] ==
        $past(fb_any && !sys_any)) else $error("fb flag bit wrong");
    stat_index_a: assert property (pf_any && !sys_any && $past(1'b1) |=>
        protection_status_word[3:0] == $past(first_idx))
        else $error("index bits wrong");
    first_bit_a: assert property (power_factor_fault_flags[0] && !sys_any
        |=> protection_status_word[3:0] == 4'h0)
        else $error("first bit not chosen");
    parity_code_a: assert property (parity_ff |=>
        protection_status_word[6:0] == psup_pkg::CODE_PARITY)
        else $error("parity code wrong");
    ov_stop_a: assert property (st_ff == psup_pkg::ST_RUN && trig[0] |=>
        rx_ff == psup_pkg::RX_STOP) else $error("overvoltage not stop");
    gate_off_a: assert property (st_ff == psup_pkg::ST_OTHERS |->
        !gate_drive_pf_en && !gate_drive_fb_en)
        else $error("gates still on");
    latch_hold_a: assert property (st_ff == psup_pkg::ST_LATCHED &&
        !pwr_cyc |=> st_ff == psup_pkg::ST_LATCHED)
        else $error("latch left");
    stop_hold_a: assert property (st_ff == psup_pkg::ST_STOPPED |=>
        uart_param_mode) else $error("stop not held");
    busy_bit_a: assert property (st_ff == psup_pkg::ST_OWNER |->
        protection_status_word[7]) else $error("busy bit low");
    lock_hyst_a: assert property ($past(v_dis) && !v_en && v_dis |=>
        supply_ok_ff == $past(supply_ok_ff))
        else $error("lockout hysteresis");
    cv_latch: cover property (st_ff == psup_pkg::ST_LATCHED);
    cv_stop:  cover property (st_ff == psup_pkg::ST_STOPPED);
    cv_wait:  cover property (st_ff == psup_pkg::ST_WAIT ##1
                              st_ff == psup_pkg::ST_OFF);
endmodule

// file: verilog/psup_pkg.sv
// psup_pkg: constants for the protection supervisor
// assumes a 20 MHz main clock; used by psup_top and its testbench
package psup_pkg;
    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int STAT_W       = 16;
    localparam int BIT_ACTIVE   = 7;
    localparam int BIT_LMG      = 6;
    localparam int BIT_FB       = 5;
    localparam int BIT_PF       = 4;
    localparam int IDX_MSB      = 3;
    localparam int SYS_MSB      = 6;
    localparam logic [6:0] CODE_NONE   = 7'h00;
    localparam logic [6:0] CODE_PARITY = 7'h45;
    localparam logic [6:0] CODE_WDOG   = 7'h46;
    localparam logic [6:0] CODE_CLKCHK = 7'h47;
    localparam logic [15:0] STAT_RESET = 16'h0000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 20;
    localparam int STEP_US      = 160;  // 4 * 40 us
    localparam int STEP_CYC     = STEP_US * CLK_MHZ;
    localparam int BLANK_US     = 100;
    localparam int BLANK_CYC    = BLANK_US * CLK_MHZ;
    localparam int WDOG_US      = 10000;
    localparam int WDOG_CYC     = WDOG_US * CLK_MHZ;
    localparam int TASK_US      = 10000;
    localparam int TASK_CYC     = TASK_US * CLK_MHZ;
    // ------------------------------------------------------------
    // reaction choices
    // ------------------------------------------------------------
    localparam logic [1:0] RX_AUTO  = 2'h0;
    localparam logic [1:0] RX_FAST  = 2'h1;
    localparam logic [1:0] RX_LATCH = 2'h2;
    localparam logic [1:0] RX_STOP  = 2'h3;
    // fault owner stage
    localparam logic [1:0] OWN_PF   = 2'h0;
    localparam logic [1:0] OWN_FB   = 2'h1;
    localparam logic [1:0] OWN_ALL  = 2'h2;
    typedef enum logic [2:0] {
        ST_OFF, ST_RUN, ST_OWNER, ST_OTHERS, ST_LATCHED, ST_STOPPED,
        ST_WAIT
    } psup_state_e;
endpackage

// file: tb/psup_host.sv
// psup_host: host that reads the status word after a chosen latency
// assumes psup_top on the same mclk with synchronous reset
`timescale 1ns/10ps
module psup_host (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // read request and its latency in cycles
    input  wire logic        rd_req,
    input  wire logic [1:0]  rd_delay,
    // device status word
    input  wire logic [15:0] status,
    // read answer
    output logic             rd_valid,
    output logic [15:0]      rd_data
);
    logic [1:0]  cnt_ff;
    logic        busy_ff;
    logic        valid_ff;
    logic [15:0] data_ff;

    // count out the latency, then take one snapshot of the code
    // data lines toggle between answers so stale values never match
    always_ff @(posedge mclk) begin
        valid_ff <= 1'b0;
        data_ff  <= ~data_ff;
        if (rst) begin
            busy_ff <= 1'b0;
            cnt_ff  <= 2'h0;
        end else if (rd_req) begin
            busy_ff <= 1'b1;
            cnt_ff  <= rd_delay;
        end else if (busy_ff && cnt_ff == 2'h0) begin
            busy_ff  <= 1'b0;
            valid_ff <= 1'b1;
            data_ff  <= status;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 2'h1;
        end
    end

    // answer outputs
    assign rd_valid = valid_ff;
    assign rd_data  = data_ff;
endmodule

// file: tb/test_protection_supervisor.sv
// test_protection_supervisor: self-checking bench for psup_top
// assumes shortened counts; host model answers status reads
`timescale 1ns/10ps
module test_protection_supervisor;
    // --------
    // stimulus and observed signals
    // --------
    localparam int RSTC = 20;
    localparam int STEP = 4;
    localparam int BLANK = 4;
    localparam int WDOG = 50;
    localparam int FASTC = 10;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] pf_fl = 16'h0;
    logic [15:0] fb_fl = 16'h0;
    logic [15:0] lm_fl = 16'h0;
    logic [1:0]  st_rx = 2'h0;
    logic [1:0]  tp_rx = 2'h0;
    logic [1:0]  uv_rx = 2'h0;
    logic [1:0]  sy_rx = 2'h0;
    logic        t_hot = 1'b0;
    logic        t_rel = 1'b1;
    logic        n_trip = 1'b0;
    logic        n_rel = 1'b1;
    logic        s_lo = 1'b0;
    logic        crc_dn = 1'b1;
    logic        s_en = 1'b1;
    logic        s_dis = 1'b1;
    logic        s_hi = 1'b0;
    logic        p_cyc = 1'b0;
    logic        kick = 1'b0;
    logic        tick = 1'b0;
    logic        kick_en = 1'b1;
    logic        par = 1'b0;
    logic [1:0]  osc = 2'h3;
    logic        crc_ok = 1'b1;
    logic [3:0]  tcnt = 4'h0;
    logic        rd_req = 1'b0;
    logic [1:0]  rd_delay = 2'h0;
    logic [3:0]  idx;
    logic [31:0] note;
    logic [31:0] expq[$];
    logic [6:0]  codes[3];
    wire  [15:0] stat;
    wire  [15:0] rd_data;
    wire         rd_valid;
    wire         g_pf;
    wire         g_fb;
    wire         psave;
    wire         uart;
    wire         crc_f;
    wire  [4:0]  obs = {g_pf, g_fb, psave, uart, crc_f};
    int          fail_count = 0;
    int          checks = 0;

    // --------
    // design, host model and clocks
    // --------
    psup_top #(.BLANK_CYCLES(BLANK), .WDOG_CYCLES(WDOG), .TASK_CYCLES(WDOG),
        .STEP_CYCLES(STEP), .RST_CYC(RSTC), .FAST_CYC(FASTC)) i_dut (
        .mclk(mclk), .rst(rst), .power_factor_fault_flags(pf_fl),
        .flyback_fault_flags(fb_fl), .light_management_fault_flags(lm_fl),
        .stage_react(st_rx), .temp_over_trip(t_hot),
        .temp_below_release(t_rel), .therm_below_trip(n_trip),
        .therm_above_release(n_rel), .supply_above_enable_level(s_en),
        .supply_above_disable_level(s_dis),
        .supply_above_high_limit(s_hi), .supply_below_low_limit(s_lo),
        .power_cycled(p_cyc), .wdog_kick(kick), .task_tick(tick),
        .parity_error(par), .osc_alive(osc), .crc_done(crc_dn),
        .crc_ok(crc_ok), .temp_react(tp_rx), .uv_react(uv_rx),
        .sys_react(sy_rx), .protection_status_word(stat),
        .gate_drive_pf_en(g_pf), .gate_drive_fb_en(g_fb),
        .power_save(psave), .uart_param_mode(uart), .crc_fail(crc_f));
    psup_host i_host (.mclk(mclk), .rst(rst), .rd_req(rd_req),
        .rd_delay(rd_delay), .status(stat), .rd_valid(rd_valid),
        .rd_data(rd_data));
    always #25 mclk = ~mclk;
    // firmware service pulses every 16 cycles
    always @(posedge mclk) begin
        tcnt <= tcnt + 4'h1;
        tick <= (tcnt == 4'h0);
        kick <= (tcnt == 4'h0) && kick_en;
    end

    // --------
    // tasks
    // --------
    task automatic cmp(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // wait, bounded, until masked outputs show want
    task automatic wait_out(input logic [4:0] want, input logic [4:0] m,
                            input int lim);
        int n;
        n = 0;
        @(negedge mclk);
        while ((obs & m) !== want && n < lim) begin
            @(negedge mclk);
            n++;
        end
        cmp("outputs", {11'h0, want}, {11'h0, obs & m});
        // hand back on a rising edge so the next drive is a clean nba
        @(posedge mclk);
    endtask
    // note the expected word, then ask the host to read it
    task automatic read_status(input logic [15:0] e, input logic [15:0] m);
        expq.push_back({m, e});
        @(posedge mclk);
        rd_req   <= 1'b1;
        rd_delay <= 2'($urandom);
        @(posedge mclk);
        rd_req <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
    endtask
    task automatic stop_test();
        if (expq.size() != 0) fail_count++;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // compare each host answer with the oldest note
    always @(negedge mclk) begin
        if (rd_valid === 1'b1) begin
            note = (expq.size() > 0) ? expq.pop_front() : 32'hffff_ffff;
            cmp("status", note[15:0], rd_data & note[31:16]);
        end
    end
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        stop_test();
    end

    // --------
    // tests
    // --------
    initial begin
        codes = '{psup_pkg::CODE_PARITY, psup_pkg::CODE_WDOG,
                  psup_pkg::CODE_CLKCHK};
        void'($urandom(57));
        do_reset();
        wait_out(5'b11000, 5'b11111, 10);
        read_status(16'h0000, 16'hffff);
        $display("test start done");
        idx = 4'($urandom);
        st_rx <= psup_pkg::RX_AUTO;
        pf_fl <= 16'h1 << idx;
        wait_out(5'b01000, 5'b11000, 3);
        wait_out(5'b00000, 5'b11000, STEP + 2);
        wait_out(5'b00100, 5'b11110, STEP + 2);
        read_status({8'h00, 4'h9, idx}, 16'hffff);
        pf_fl <= 16'h0;
        repeat (RSTC - 12) @(negedge mclk);
        wait_out(5'b00100, 5'b11110, 0);
        wait_out(5'b11000, 5'b11110, 12);
        $display("test auto restart done");
        st_rx <= psup_pkg::RX_FAST;
        fb_fl <= 16'h0208;
        lm_fl <= 16'h0004;
        wait_out(5'b00100, 5'b11110, 2 * STEP + 6);
        read_status(16'h00e3, 16'hffff);
        fb_fl <= 16'h0;
        lm_fl <= 16'h0;
        wait_out(5'b11000, 5'b11110, 8);
        $display("test fast restart done");
        tp_rx <= psup_pkg::RX_LATCH;
        t_hot <= 1'b1;
        repeat (2) @(posedge mclk);
        t_hot <= 1'b0;
        repeat (10) @(negedge mclk);
        wait_out(5'b11000, 5'b11110, 0);
        t_hot <= 1'b1;
        wait_out(5'b00000, 5'b11110, 20);
        t_hot <= 1'b0;
        repeat (40) @(negedge mclk);
        wait_out(5'b00000, 5'b11110, 0);
        @(posedge mclk);
        p_cyc <= 1'b1;
        repeat (3) @(posedge mclk);
        p_cyc <= 1'b0;
        wait_out(5'b11000, 5'b11110, 20);
        $display("test latch done");
        tp_rx  <= psup_pkg::RX_AUTO;
        uv_rx  <= psup_pkg::RX_FAST;
        n_trip <= 1'b1;
        n_rel  <= 1'b0;
        t_rel  <= 1'b0;
        wait_out(5'b00100, 5'b11110, 30);
        n_trip <= 1'b0;
        repeat (RSTC + 4) @(negedge mclk);
        wait_out(5'b00100, 5'b11110, 0);
        t_rel <= 1'b1;
        repeat (4) @(negedge mclk);
        wait_out(5'b00100, 5'b11110, 0);
        n_rel <= 1'b1;
        wait_out(5'b11000, 5'b11110, 8);
        s_lo <= 1'b1;
        wait_out(5'b00100, 5'b11110, 30);
        s_lo  <= 1'b0;
        pf_fl <= 16'h0001;
        read_status(16'h0090, 16'hffff);
        pf_fl <= 16'h0;
        wait_out(5'b11000, 5'b11110, FASTC + 6);
        $display("test temp release and undervoltage done");
        uv_rx <= psup_pkg::RX_AUTO;
        s_hi  <= 1'b1;
        wait_out(5'b00010, 5'b11110, 30);
        s_hi <= 1'b0;
        do_reset();
        s_en <= 1'b0;
        repeat (10) @(negedge mclk);
        wait_out(5'b11000, 5'b11000, 0);
        s_dis <= 1'b0;
        wait_out(5'b00000, 5'b11000, 10);
        s_en  <= 1'b1;
        s_dis <= 1'b1;
        wait_out(5'b11000, 5'b11000, 10);
        $display("test supply done");
        sy_rx <= psup_pkg::RX_STOP;
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            par     <= (k == 0);
            kick_en <= (k != 1);
            osc     <= (k == 2) ? 2'h1 : 2'h3;
            @(posedge mclk);
            par <= 1'b0;
            wait_out(5'b00010, 5'b11110, 80);
            read_status({9'h0, codes[k]}, 16'hff7f);
            kick_en <= 1'b1;
            osc     <= 2'h3;
            do_reset();
            wait_out(5'b11000, 5'b11110, 10);
        end
        $display("test system codes done");
        crc_ok <= 1'b0;
        crc_dn <= 1'b0;
        do_reset();
        wait_out(5'b11000, 5'b11001, 10);
        crc_dn <= 1'b1;
        do_reset();
        wait_out(5'b00001, 5'b11001, 20);
        repeat (20) @(negedge mclk);
        wait_out(5'b00001, 5'b11001, 0);
        $display("test crc done");
        stop_test();
    end
endmodule
